// file: hw/io_decoder.sv
`timescale 1ns/10ps
// Notes on behaviour
// - in enhanced and expanded-only modes every internal peripheral answers in the expanded window F000-F8FF.
// - only timer, interrupt, serial and DMA units may appear at 0-3FF.
// - legacy mode maps the four units low, compares ten bits only.
// - enhanced mode compares sixteen bits; expanded plus low window both answer.
// - expanded-only mode compares all bits; nothing answers in the low window.
// - nonintrusive mode lets each legacy unit be unmapped; ten bits only.
module io_decoder #(
	parameter logic [39:0] BASES = {io_decode_pkg::LEG_BASE_3,
		io_decode_pkg::LEG_BASE_2, io_decode_pkg::LEG_BASE_1,
		io_decode_pkg::LEG_BASE_0},
	parameter logic [9:0]  SIZE  = io_decode_pkg::LEG_SIZE
) (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	// configuration
	input  wire logic [1:0]  mode,
	input  wire logic [3:0]  unmap,
	// request from the core
	input  wire logic        io_req,
	input  wire logic [15:0] io_addr,
	// decode answer
	output logic             done_r,
	output logic             claim_r,
	output logic             ext_r,
	output logic             exp_sel_r,
	output logic [3:0]       unit_sel_r,
	output logic [11:0]      exp_off_r
);
	typedef struct packed {
		logic        done;
		logic        claim;
		logic        ext;
		logic        exp_sel;
		logic [3:0]  unit_sel;
		logic [11:0] exp_off;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	legacy_match_if lm ();

	legacy_match #(
		.BASES (BASES),
		.SIZE  (SIZE)
	) u_match (
		.m (lm.match)
	);

	assign lm.low_addr = io_addr[io_decode_pkg::LOW_BITS-1:0];

	logic        ten_bit;
	logic        low_ok;
	logic        exp_hit;
	logic [3:0]  leg_hit;
	logic [15:0] exp_diff;

	always_comb begin
		ten_bit  = (mode == io_decode_pkg::MODE_LEGACY)
			|| (mode == io_decode_pkg::MODE_NONINTR);
		// full compare requires upper bits clear for the low window
		low_ok   = ten_bit || (io_addr <= io_decode_pkg::LOW_HI);
		exp_hit  = !ten_bit && (io_addr >= io_decode_pkg::EXP_LO)
			&& (io_addr <= io_decode_pkg::EXP_HI);
		exp_diff = io_addr - io_decode_pkg::EXP_LO;
		leg_hit  = 4'h0;
		case (mode)
			io_decode_pkg::MODE_LEGACY:  leg_hit = lm.hit;
			io_decode_pkg::MODE_ENHANCE: begin
				leg_hit = low_ok ? lm.hit : 4'h0;
			end
			io_decode_pkg::MODE_EXPONLY: leg_hit = 4'h0;
			io_decode_pkg::MODE_NONINTR: leg_hit = lm.hit & ~unmap;
			default:                     leg_hit = 4'h0;
		endcase
		st_nxt          = st_r;
		st_nxt.done     = io_req;
		if (io_req) begin
			st_nxt.unit_sel = leg_hit;
			st_nxt.exp_sel  = exp_hit;
			st_nxt.exp_off  = exp_hit ? exp_diff[11:0] : 12'h000;
			st_nxt.claim    = exp_hit || (leg_hit != 4'h0);
			st_nxt.ext      = !(exp_hit || (leg_hit != 4'h0));
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign done_r     = st_r.done;
	assign claim_r    = st_r.claim;
	assign ext_r      = st_r.ext;
	assign exp_sel_r  = st_r.exp_sel;
	assign unit_sel_r = st_r.unit_sel;
	assign exp_off_r  = st_r.exp_off;

	// checks
	// request inside the expanded window, any mode
	sequence s_req_exp;
		io_req && io_addr >= io_decode_pkg::EXP_LO
			&& io_addr <= io_decode_pkg::EXP_HI;
	endsequence

	// request outside the expanded window
	sequence s_req_not_exp;
		io_req && (io_addr < io_decode_pkg::EXP_LO
			|| io_addr > io_decode_pkg::EXP_HI);
	endsequence

	// request under each addressing mode
	sequence s_req_legacy;
		io_req && mode == io_decode_pkg::MODE_LEGACY;
	endsequence

	sequence s_req_enh;
		io_req && mode == io_decode_pkg::MODE_ENHANCE;
	endsequence

	sequence s_req_exponly;
		io_req && mode == io_decode_pkg::MODE_EXPONLY;
	endsequence

	sequence s_req_nonintr;
		io_req && mode == io_decode_pkg::MODE_NONINTR;
	endsequence

	// the two modes that compare all sixteen bits
	sequence s_req_full;
		s_req_enh or s_req_exponly;
	endsequence

	// the two modes that compare ten bits only
	sequence s_req_ten;
		s_req_legacy or s_req_nonintr;
	endsequence

	// enhanced-mode request with the upper address bits clear
	sequence s_req_enh_low;
		s_req_enh ##0 io_addr[15:io_decode_pkg::LOW_BITS] == 6'h00;
	endsequence

	// enhanced-mode request with some upper address bit set
	sequence s_req_enh_high;
		s_req_enh ##0 io_addr[15:io_decode_pkg::LOW_BITS] != 6'h00;
	endsequence

	a_exp_window_hit: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		(s_req_exp and s_req_full) |=> exp_sel_r && claim_r
			&& exp_off_r == 12'($past(io_addr)
			- io_decode_pkg::EXP_LO))
		else $error("expanded access not claimed");

	a_ten_bit_exp: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		(s_req_exp and s_req_ten) |=> !exp_sel_r)
		else $error("expanded window reached in a ten-bit mode");

	a_exp_outside: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		s_req_not_exp |=> !exp_sel_r && exp_off_r == 12'h000)
		else $error("expanded select outside its window");

	a_unit_low_only: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		done_r && unit_sel_r != 4'h0 |-> !exp_sel_r
			&& $past(mode) != io_decode_pkg::MODE_EXPONLY)
		else $error("legacy unit selected outside low window");

	a_legacy_no_exp: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		s_req_legacy |=> !exp_sel_r && unit_sel_r == $past(lm.hit))
		else $error("legacy mode decode wrong");

	a_enh_upper_bits: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		s_req_enh_high |=> unit_sel_r == 4'h0)
		else $error("enhanced mode aliased low window");

	a_enh_low_hit: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		s_req_enh_low |=> unit_sel_r == $past(lm.hit) && !exp_sel_r)
		else $error("enhanced mode missed low window");

	a_exponly_no_low: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		s_req_exponly |=> unit_sel_r == 4'h0
			&& exp_sel_r == ($past(io_addr) >= io_decode_pkg::EXP_LO
			&& $past(io_addr) <= io_decode_pkg::EXP_HI))
		else $error("expanded-only mode answered low");

	a_nonint_unmap: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		s_req_nonintr |=> (unit_sel_r & $past(unmap)) == 4'h0
			&& !exp_sel_r)
		else $error("unmapped unit still selected");

	a_nonint_kept: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		s_req_nonintr |=> (unit_sel_r | $past(unmap))
			== ($past(lm.hit) | $past(unmap)))
		else $error("mapped unit dropped from low window");

	a_ext_when_none: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		io_req ##1 done_r |-> ext_r == (unit_sel_r == 4'h0 && !exp_sel_r)
			&& claim_r == !ext_r)
		else $error("claim and external disagree");

	a_done_pulse: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		io_req |=> done_r)
		else $error("answer missing one cycle after request");

	a_done_idle: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		!io_req |=> !done_r)
		else $error("answer without a request");

	a_hold_idle: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		!io_req |=> $stable({claim_r, ext_r, exp_sel_r, unit_sel_r,
			exp_off_r}))
		else $error("decode answer changed without a request");
endmodule

// file: hw/io_decode_pkg.sv
package io_decode_pkg;
	// addressing modes
	localparam logic [1:0] MODE_LEGACY  = 2'h0;
	localparam logic [1:0] MODE_ENHANCE = 2'h1;
	localparam logic [1:0] MODE_EXPONLY = 2'h2;
	localparam logic [1:0] MODE_NONINTR = 2'h3;
	// windows
	localparam logic [15:0] EXP_LO      = 16'hF000;
	localparam logic [15:0] EXP_HI      = 16'hF8FF;
	localparam logic [15:0] LOW_HI      = 16'h03FF;
	localparam int          LOW_BITS    = 10;
	localparam int          NUM_LEGACY  = 4;
	// legacy unit indices
	localparam int          U_TIMER     = 0;
	localparam int          U_INTC      = 1;
	localparam int          U_SERIAL    = 2;
	localparam int          U_DMA       = 3;
	// default legacy placement inside the low window
	localparam logic [9:0]  LEG_BASE_0  = 10'h040;
	localparam logic [9:0]  LEG_BASE_1  = 10'h020;
	localparam logic [9:0]  LEG_BASE_2  = 10'h3F8;
	localparam logic [9:0]  LEG_BASE_3  = 10'h000;
	localparam logic [9:0]  LEG_SIZE    = 10'h008;
endpackage

// file: hw/legacy_match_if.sv
`timescale 1ns/10ps
interface legacy_match_if;
	logic [9:0] low_addr;
	logic [3:0] hit;
	modport ctrl (output low_addr, input hit);
	modport match (input low_addr, output hit);
endinterface

// file: hw/legacy_match.sv
`timescale 1ns/10ps
// compares the low ten address bits against each legacy unit's range
module legacy_match #(
	parameter logic [39:0] BASES = {io_decode_pkg::LEG_BASE_3,
		io_decode_pkg::LEG_BASE_2, io_decode_pkg::LEG_BASE_1,
		io_decode_pkg::LEG_BASE_0},
	parameter logic [9:0]  SIZE  = io_decode_pkg::LEG_SIZE
) (
	legacy_match_if.match m
);
	genvar i;
	generate
		for (i = 0; i < io_decode_pkg::NUM_LEGACY; i++) begin : g_unit
			logic [10:0] top;
			assign top = {1'b0, BASES[i*10 +: 10]} + {1'b0, SIZE};
			assign m.hit[i] = ({1'b0, m.low_addr} >= {1'b0, BASES[i*10 +: 10]})
				&& ({1'b0, m.low_addr} < top);
		end
	endgenerate
endmodule

// file: bench/core_model.sv
`timescale 1ns/10ps
// processor core side: one-cycle I/O requests
module core_model (
	input  wire logic        core_clk,
	output logic             io_req,
	output logic [15:0]      io_addr
);
	initial begin
		io_req  = 1'h0;
		io_addr = 16'h0000;
	end
	task automatic issue(input logic [15:0] a);
		@(negedge core_clk);
		io_req  = 1'h1;
		io_addr = a;
		@(negedge core_clk);
		io_req  = 1'h0;
		// stale address is inverted so it is never mistaken for valid
		io_addr = ~a;
	endtask
endmodule

// file: bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	logic        core_clk;
	logic        arst_n;
	logic [1:0]  mode;
	logic [3:0]  unmap;
	logic        io_req;
	logic [15:0] io_addr;
	logic        done_r;
	logic        claim_r;
	logic        ext_r;
	logic        exp_sel_r;
	logic [3:0]  unit_sel_r;
	logic [11:0] exp_off_r;
	logic [19:0] seen_all;
	int          failures = 0;
	int          checks = 0;
	logic [15:0] base [4] = '{{6'h00, io_decode_pkg::LEG_BASE_0},
		{6'h00, io_decode_pkg::LEG_BASE_1},
		{6'h00, io_decode_pkg::LEG_BASE_2},
		{6'h00, io_decode_pkg::LEG_BASE_3}};
	localparam logic [18:0] NONE = {1'h0, 1'h1, 17'h00000};
	core_model core_u (.core_clk(core_clk), .io_req(io_req),
		.io_addr(io_addr));
	io_decoder dut_u (.core_clk(core_clk), .arst_n(arst_n), .mode(mode),
		.unmap(unmap), .io_req(io_req), .io_addr(io_addr), .done_r(done_r),
		.claim_r(claim_r), .ext_r(ext_r), .exp_sel_r(exp_sel_r),
		.unit_sel_r(unit_sel_r), .exp_off_r(exp_off_r));
	assign seen_all = {done_r, claim_r, ext_r, exp_sel_r, unit_sel_r,
		exp_off_r};
	function automatic logic [18:0] u(input logic [3:0] x);
		return {1'h1, 1'h0, 1'h0, x, 12'h000};
	endfunction
	function automatic logic [18:0] x(input logic [11:0] off);
		return {1'h1, 1'h0, 1'h1, 4'h0, off};
	endfunction
	task automatic chk(input logic [19:0] seen, input logic [19:0] e);
		checks++;
		if (seen !== e) begin
			failures++;
			$display("BAD %0t seen %h expected %h", $time, seen, e);
		end
	endtask
	// drive mode and unmap, issue one access, judge the answer
	task automatic run(input logic [1:0] m, input logic [3:0] um,
		input logic [15:0] a, input logic [18:0] e);
		@(negedge core_clk);
		mode  = m;
		unmap = um;
		core_u.issue(a);
		chk(seen_all, {1'h1, e});
		// pulse gone, decode stands until the next request
		@(negedge core_clk);
		chk(seen_all, {1'h0, e});
	endtask
	task automatic t_legacy();
		run(io_decode_pkg::MODE_LEGACY, 4'h0, 16'h0040, u(4'h1));
		run(io_decode_pkg::MODE_LEGACY, 4'h0, 16'h0440, u(4'h1));
		run(io_decode_pkg::MODE_LEGACY, 4'h0, 16'h03F8, u(4'h4));
		run(io_decode_pkg::MODE_LEGACY, 4'h0, 16'hF010, NONE);
		$display("legacy test ended");
	endtask
	task automatic t_enhance();
		run(io_decode_pkg::MODE_ENHANCE, 4'h0, 16'hF010, x(12'h010));
		run(io_decode_pkg::MODE_ENHANCE, 4'h0, 16'hF8FF, x(12'h8FF));
		run(io_decode_pkg::MODE_ENHANCE, 4'h0, 16'h0020, u(4'h2));
		run(io_decode_pkg::MODE_ENHANCE, 4'h0, 16'h0440, NONE);
		run(io_decode_pkg::MODE_ENHANCE, 4'h0, 16'hF900, NONE);
		$display("enhanced test ended");
	endtask
	task automatic t_exponly();
		run(io_decode_pkg::MODE_EXPONLY, 4'h0, 16'h0007, NONE);
		run(io_decode_pkg::MODE_EXPONLY, 4'h0, 16'hF000, x(12'h000));
		$display("expanded-only test ended");
	endtask
	task automatic t_nonintr();
		for (int i = 0; i < 4; i++) begin
			run(io_decode_pkg::MODE_NONINTR, 4'h1 << i, base[i], NONE);
			run(io_decode_pkg::MODE_NONINTR, 4'h1 << i, base[(i + 1) % 4],
				u(4'h1 << ((i + 1) % 4)));
		end
		run(io_decode_pkg::MODE_NONINTR, 4'h0, 16'hF010, NONE);
		$display("nonintrusive test ended");
	endtask
	task automatic t_reset();
		run(io_decode_pkg::MODE_ENHANCE, 4'h0, 16'hF020, x(12'h020));
		arst_n = 1'h0;
		#1;
		chk(seen_all, 20'h00000);
		@(negedge core_clk);
		arst_n = 1'h1;
		run(io_decode_pkg::MODE_NONINTR, 4'h0, 16'h0000, u(4'h8));
		$display("reset test ended");
	endtask
	task automatic end_sim();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		core_clk = 1'h0;
		forever #4 core_clk = ~core_clk;
	end
	initial begin
		#200000;
		failures++;
		end_sim();
	end
	initial begin
		arst_n = 1'h0;
		mode   = 2'h0;
		unmap  = 4'h0;
		repeat (12) @(negedge core_clk);
		arst_n = 1'h1;
		@(negedge core_clk);
		chk(seen_all, 20'h00000);
		t_legacy();
		t_enhance();
		t_exponly();
		t_nonintr();
		t_reset();
		end_sim();
	end
endmodule
